// ===== rtl/uirq_pkg.sv
/*
 * Constants of the USB endpoint flag and frame-number register block.
 * Assumes a 32-bit APB master; each register takes one aligned word.
 */
//
// Operation
// RULE_01: Frame-number-high shows bits 10 to 8 of the last received frame number in its bits 2 to 0.
// RULE_02: Bits 7 to 3 of frame-number-high read zero and ignore writes.
// RULE_03: The USB interrupt request is high whenever an enabled pending flag is one.
// RULE_04: Reading the flag register clears every flag in it as a side effect. The code clears only the flags that the read returned.
// RULE_05: Software writes neither set nor clear the pending flags.
// RULE_06: Each pending flag has its own enable bit in a separate enable register.
// RULE_07: Software enables the USB interrupt at processor level before expecting service.
// RULE_08: Bits 7 to 4 of the IN-endpoint flag register read zero and ignore writes.
// RULE_09: IN endpoints 3, 2 and 1 hold their pending flags at bits 3, 2 and 1.
// RULE_10: The control endpoint holds its pending flag at bit 0.
// RULE_11: A flag event in the same cycle as a clearing read leaves the flag set.
package uirq_pkg;

   // Register indices; byte address is four times the index
   localparam logic [5:0]  UIRQ_IDX_IN_FLAGS  = 6'h02;
   localparam logic [5:0]  UIRQ_IDX_FRAME_HI  = 6'h0d;
   localparam logic [5:0]  UIRQ_IDX_IN_ENABLE = 6'h07;
   localparam logic [5:0]  UIRQ_IDX_IRQ_STAT  = 6'h10;
   localparam logic [5:0]  UIRQ_IDX_IRQ_MASK  = 6'h11;

   // Register widths and field positions
   localparam int          UIRQ_REG_W         = 8;
   localparam int          UIRQ_NUM_IN_EP     = 4;
   localparam int          UIRQ_FRAME_W       = 11;
   localparam int          UIRQ_FRAME_HI_LSB  = 8;
   localparam int          UIRQ_FRAME_HI_W    = 3;
   localparam int          UIRQ_EV_FLAG_BIT   = 0;
   localparam int          UIRQ_EV_FRAME_BIT  = 1;
   localparam int          UIRQ_EV_W          = 2;

   // Reset values
   localparam logic [7:0]  UIRQ_RST_IN_FLAGS  = 8'h00;
   localparam logic [7:0]  UIRQ_RST_FRAME_HI  = 8'h00;
   localparam logic [7:0]  UIRQ_RST_IN_ENABLE = 8'h0f;
   localparam logic [7:0]  UIRQ_RST_IRQ_STAT  = 8'h00;
   localparam logic [7:0]  UIRQ_RST_IRQ_MASK  = 8'h00;

   // Bus slave states
   typedef enum logic [1:0] {
      UIRQ_ST_IDLE   = 2'b00,
      UIRQ_ST_ANSWER = 2'b01
   } uirq_bus_st_t;

endpackage

// ===== rtl/uirq_reg_if.sv
/*
 * Internal register access carrier between the APB slave and the register file.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/1ps
interface uirq_reg_if;
   logic [5:0] idx;        // Register index
   logic [7:0] wdata;      // Low byte of write data
   logic       capture;    // Access phase, first cycle
   logic       commit;     // Completing edge of the transfer
   logic       write;      // Direction
   logic [7:0] rdata;      // Read value of the addressed register
   logic       hit;        // Address is mapped

   modport bus  (output idx, wdata, capture, commit, write, input rdata, hit);
   modport regs (input idx, wdata, capture, commit, write, output rdata, hit);
endinterface

// ===== rtl/uirq_flag_bank.sv
/*
 * Bank of sticky flags: hardware sets, a clear mask drops them.
 * Assumes clear masks are one-cycle pulses from the register file.
 */
`timescale 1ns/1ps
module uirq_flag_bank #(
   parameter int          W       = 4,
   parameter logic [7:0]  RST_VAL = 8'h00
) (
   // Clock and reset
   input  wire logic         clk_sys_in,
   input  wire logic         rst_b_in,
   // Set and clear
   input  wire logic [W-1:0] set_in,
   input  wire logic [W-1:0] clr_in,
   // State
   output logic      [W-1:0] flags_out
);
   logic [W-1:0] flags_r;
   logic [W-1:0] flags_nxt;

   // Bank cannot exceed one register byte
   if (W < 1 || W > 8)
      $error("flag bank width out of range");

   // One bit per flag; a set in the clear cycle survives
   for (genvar i = 0; i < W; i++)
   begin : g_bit
      always_comb
      begin
         flags_nxt[i] = (flags_r[i] & ~clr_in[i]) | set_in[i]; // RULE_11
      end
   end

   // Registered state
   always_ff @(posedge clk_sys_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
         flags_r <= RST_VAL[W-1:0];
      else
         flags_r <= flags_nxt;
   end

   assign flags_out = flags_r;
endmodule

// ===== rtl/uirq_apb_slave.sv
/*
 * APB slave front end: one answer cycle after the first access cycle.
 * Assumes an APB3 master; data lanes above bit 7 are ignored on writes.
 */
`timescale 1ns/1ps
module uirq_apb_slave
   import uirq_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_sys_in,
   input  wire logic        rst_b_in,
   // APB
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [7:0]  paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic             pready_out,
   output logic [31:0]      prdata_out,
   output logic             pslverr_out,
   // Register side
   uirq_reg_if.bus          rif
);
   import uirq_pkg::*;

   uirq_bus_st_t st_r;
   uirq_bus_st_t st_nxt;
   logic         pready_r;
   logic         pready_nxt;
   logic [31:0]  prdata_r;
   logic [31:0]  prdata_nxt;
   logic         pslverr_r;
   logic         pslverr_nxt;
   logic         access;

   // Request fields pass straight through; the master holds them
   assign access      = psel_in & penable_in;
   assign rif.idx     = paddr_in[7:2];
   assign rif.wdata   = pwdata_in[7:0];
   assign rif.write   = pwrite_in;
   assign rif.capture = access & (st_r == UIRQ_ST_IDLE);
   assign rif.commit  = access & (st_r == UIRQ_ST_ANSWER) & rif.hit;

   // Read data sampled a cycle early so pready and prdata leave flops
   always_comb
   begin
      st_nxt      = st_r;
      pready_nxt  = 1'b0;
      prdata_nxt  = prdata_r;
      pslverr_nxt = 1'b0;
      case (st_r)
         UIRQ_ST_IDLE:
         begin
            if (access)
            begin
               st_nxt      = UIRQ_ST_ANSWER;
               pready_nxt  = 1'b1;
               pslverr_nxt = ~rif.hit;
               prdata_nxt  = pwrite_in ? 32'h0000_0000 : {24'h00_0000, rif.rdata};
            end
         end
         UIRQ_ST_ANSWER:
         begin
            st_nxt = UIRQ_ST_IDLE;
         end
         default:
         begin
            st_nxt = UIRQ_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         st_r      <= UIRQ_ST_IDLE;
         pready_r  <= 1'b0;
         prdata_r  <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end
      else
      begin
         st_r      <= st_nxt;
         pready_r  <= pready_nxt;
         prdata_r  <= prdata_nxt;
         pslverr_r <= pslverr_nxt;
      end
   end

   assign pready_out  = pready_r;
   assign prdata_out  = prdata_r;
   assign pslverr_out = pslverr_r;
endmodule

// ===== rtl/uirq_top.sv
/*
 * USB endpoint interrupt-pending flags, frame-number-high register,
 * per-flag enables, the USB interrupt request and a system event
 * status/mask pair, all reached over APB.
 * Assumes flag events and frame strobes are synchronous one-cycle pulses
 * from the protocol engine on the same clock.
 */
`timescale 1ns/1ps
module uirq_top #(
   parameter int NUM_IN_EP = uirq_pkg::UIRQ_NUM_IN_EP
) (
   // Clock and reset
   input  wire logic                              clk_sys_in,
   input  wire logic                              rst_b_in,
   // APB
   input  wire logic                              psel_in,
   input  wire logic                              penable_in,
   input  wire logic                              pwrite_in,
   input  wire logic [7:0]                        paddr_in,
   input  wire logic [31:0]                       pwdata_in,
   output logic                                   pready_out,
   output logic [31:0]                            prdata_out,
   output logic                                   pslverr_out,
   // Protocol engine events
   input  wire logic [NUM_IN_EP-1:0]              in_ep_event_in,
   input  wire logic                              frame_valid_in,
   input  wire logic [uirq_pkg::UIRQ_FRAME_W-1:0] frame_number_in,
   // Interrupts
   output logic                                   usb_irq_out,
   output logic                                   irq_out
);
   import uirq_pkg::*;

   // Flag bank layout must fit the IN-endpoint register
   if (NUM_IN_EP != UIRQ_NUM_IN_EP)
      $error("NUM_IN_EP must equal the IN-endpoint register layout");

   uirq_reg_if rif ();

   // Register file state
   logic [NUM_IN_EP-1:0]       flags;
   logic [NUM_IN_EP-1:0]       flags_clr;
   logic [NUM_IN_EP-1:0]       snap_r;
   logic [NUM_IN_EP-1:0]       snap_nxt;
   logic [UIRQ_FRAME_HI_W-1:0] frame_hi_r;
   logic [UIRQ_FRAME_HI_W-1:0] frame_hi_nxt;
   logic [NUM_IN_EP-1:0]       enable_r;
   logic [NUM_IN_EP-1:0]       enable_nxt;
   logic [UIRQ_EV_W-1:0]       ev_stat;
   logic [UIRQ_EV_W-1:0]       ev_set;
   logic [UIRQ_EV_W-1:0]       ev_clr;
   logic [UIRQ_EV_W-1:0]       ev_mask_r;
   logic [UIRQ_EV_W-1:0]       ev_mask_nxt;
   logic                       usb_irq_r;
   logic                       usb_irq_nxt;
   logic                       irq_r;
   logic                       irq_nxt;
   logic                       wr_commit;
   logic                       rd_commit;

   // Bus front end
   uirq_apb_slave u_apb (
      .clk_sys_in  (clk_sys_in),
      .rst_b_in    (rst_b_in),
      .psel_in     (psel_in),
      .penable_in  (penable_in),
      .pwrite_in   (pwrite_in),
      .paddr_in    (paddr_in),
      .pwdata_in   (pwdata_in),
      .pready_out  (pready_out),
      .prdata_out  (prdata_out),
      .pslverr_out (pslverr_out),
      .rif         (rif.bus)
   );

   // Endpoint pending flags: set by the engine only
   uirq_flag_bank #(
      .W       (NUM_IN_EP),
      .RST_VAL (UIRQ_RST_IN_FLAGS)
   ) u_in_flags (
      .clk_sys_in (clk_sys_in),
      .rst_b_in   (rst_b_in),
      .set_in     (in_ep_event_in),  // RULE_05
      .clr_in     (flags_clr),
      .flags_out  (flags)
   );

   // System event status, cleared by writing ones
   uirq_flag_bank #(
      .W       (UIRQ_EV_W),
      .RST_VAL (UIRQ_RST_IRQ_STAT)
   ) u_ev_stat (
      .clk_sys_in (clk_sys_in),
      .rst_b_in   (rst_b_in),
      .set_in     (ev_set),
      .clr_in     (ev_clr),
      .flags_out  (ev_stat)
   );

   // Commit strobes split by direction
   assign wr_commit = rif.commit & rif.write;
   assign rd_commit = rif.commit & ~rif.write;

   // Read of the flag register clears only what that read returned,
   // so a flag raised between sampling and completion is not lost
   always_comb
   begin
      flags_clr = '0;
      if (rd_commit && rif.idx == UIRQ_IDX_IN_FLAGS)
         flags_clr = snap_r;  // RULE_04
   end

   // Snapshot of the flags at the sampling cycle of a read
   always_comb
   begin
      snap_nxt = snap_r;
      if (rif.capture)
         snap_nxt = flags;
   end

   always_ff @(posedge clk_sys_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
         snap_r <= '0;
      else
         snap_r <= snap_nxt;
   end

   // Frame-number high bits latched on every received frame
   always_comb
   begin
      frame_hi_nxt = frame_hi_r;
      if (frame_valid_in)
         frame_hi_nxt = frame_number_in[UIRQ_FRAME_HI_LSB +: UIRQ_FRAME_HI_W];  // RULE_01
   end

   always_ff @(posedge clk_sys_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
         frame_hi_r <= UIRQ_RST_FRAME_HI[UIRQ_FRAME_HI_W-1:0];
      else
         frame_hi_r <= frame_hi_nxt;
   end

   // Software-written enables and event mask
   always_comb
   begin
      enable_nxt  = enable_r;
      ev_mask_nxt = ev_mask_r;
      ev_clr      = '0;
      if (wr_commit)
      begin
         case (rif.idx)
            UIRQ_IDX_IN_ENABLE: enable_nxt  = rif.wdata[NUM_IN_EP-1:0];  // RULE_06
            UIRQ_IDX_IRQ_MASK:  ev_mask_nxt = rif.wdata[UIRQ_EV_W-1:0];
            UIRQ_IDX_IRQ_STAT:  ev_clr      = rif.wdata[UIRQ_EV_W-1:0];
            default:            enable_nxt  = enable_r;
         endcase
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         enable_r  <= UIRQ_RST_IN_ENABLE[NUM_IN_EP-1:0];
         ev_mask_r <= UIRQ_RST_IRQ_MASK[UIRQ_EV_W-1:0];
      end
      else
      begin
         enable_r  <= enable_nxt;
         ev_mask_r <= ev_mask_nxt;
      end
   end

   // Events that feed the system status register
   always_comb
   begin
      ev_set                    = '0;
      ev_set[UIRQ_EV_FLAG_BIT]  = |in_ep_event_in;
      ev_set[UIRQ_EV_FRAME_BIT] = frame_valid_in;
   end

   // Read multiplexer; unused upper bits read zero
   always_comb
   begin
      rif.rdata = 8'h00;
      rif.hit   = 1'b1;
      case (rif.idx)
         UIRQ_IDX_IN_FLAGS:
            rif.rdata[NUM_IN_EP-1:0] = flags;  // RULE_08 RULE_09 RULE_10
         UIRQ_IDX_FRAME_HI:
            rif.rdata[UIRQ_FRAME_HI_W-1:0] = frame_hi_r;  // RULE_02
         UIRQ_IDX_IN_ENABLE:
            rif.rdata[NUM_IN_EP-1:0] = enable_r;
         UIRQ_IDX_IRQ_STAT:
            rif.rdata[UIRQ_EV_W-1:0] = ev_stat;
         UIRQ_IDX_IRQ_MASK:
            rif.rdata[UIRQ_EV_W-1:0] = ev_mask_r;
         default:
            rif.hit = 1'b0;
      endcase
   end

   // Request lines; one cycle behind the flags to leave a flop
   always_comb
   begin
      usb_irq_nxt = |(flags & enable_r);  // RULE_03
      irq_nxt     = |(ev_stat & ev_mask_r);
   end

   always_ff @(posedge clk_sys_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         usb_irq_r <= 1'b0;
         irq_r     <= 1'b0;
      end
      else
      begin
         usb_irq_r <= usb_irq_nxt;
         irq_r     <= irq_nxt;
      end
   end

   assign usb_irq_out = usb_irq_r;
   assign irq_out     = irq_r;
endmodule

// ===== dv/uirq_assertions.sv
/* Checker for the flag and frame register block.
   Sees only the top ports; bound to every uirq_top. */
`timescale 1ns/1ps
module uirq_assertions #(
   parameter int NUM_IN_EP = 4
) (
   input wire logic                 clk_sys_in,
   input wire logic                 rst_b_in,
   input wire logic                 pwrite_in,
   input wire logic [7:0]           paddr_in,
   input wire logic [31:0]          pwdata_in,
   input wire logic                 psel_in,
   input wire logic                 penable_in,
   input wire logic                 pready_out,
   input wire logic [31:0]          prdata_out,
   input wire logic                 pslverr_out,
   input wire logic [NUM_IN_EP-1:0] in_ep_event_in,
   input wire logic                 frame_valid_in,
   input wire logic [10:0]          frame_number_in,
   input wire logic                 usb_irq_out
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!rst_b_in);
   logic [2:0] fh_r, fh_nxt;
   logic [3:0] en_r, en_nxt;
   wire        rd = pready_out && !pwrite_in;
   wire        wr = pready_out && pwrite_in;
   // Shadows of frame high bits and enables, to judge the outputs
   always_comb
   begin
      fh_nxt = frame_valid_in ? frame_number_in[10:8] : fh_r;
      en_nxt = (wr && paddr_in == 8'h1c) ? pwdata_in[3:0] : en_r;
   end
   always_ff @(posedge clk_sys_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         fh_r <= 3'h0;
         en_r <= 4'hf;
      end
      else
      begin
         fh_r <= fh_nxt;
         en_r <= en_nxt;
      end
   end
   a_reset_quiet: assert property ($rose(rst_b_in) |->
      !pready_out && !pslverr_out && !usb_irq_out && prdata_out == 32'h0)
      else $error("outputs not quiet after reset release");
   a_ready_pulse: assert property ($rose(penable_in) && psel_in |=> pready_out ##1 !pready_out)
      else $error("pready not a single pulse after access");
   a_frame_high: assert property (rd && paddr_in == 8'h34 |-> prdata_out == {29'h0, $past(fh_r)})
      else $error("frame high read wrong");
   a_in_upper: assert property (rd && paddr_in == 8'h08 |-> prdata_out[31:4] == 28'h0)
      else $error("flag register upper bits set");
   a_in_bits: assert property (rd && paddr_in == 8'h08 |->
      (prdata_out[3:0] & $past(in_ep_event_in, 2)) == $past(in_ep_event_in, 2))
      else $error("flag bit missing in read");
   a_irq_event: assert property ((in_ep_event_in & en_r) != 0 && !(wr && paddr_in == 8'h1c) |-> ##2 usb_irq_out)
      else $error("enabled event raised no request");
   a_read_clear: assert property (rd && paddr_in == 8'h08 && in_ep_event_in == 0 &&
      $past(in_ep_event_in) == 0 |-> ##2 !usb_irq_out)
      else $error("flags survived a read");
   a_write_keep: assert property (wr && paddr_in == 8'h08 ##1 usb_irq_out |=> usb_irq_out)
      else $error("write cleared flags");
   a_same_cycle: assert property (rd && paddr_in == 8'h08 && (in_ep_event_in & en_r) != 0 |-> ##2 usb_irq_out)
      else $error("event lost in clearing read");
   a_unmapped: assert property (pready_out && !(paddr_in[7:2] inside {6'h02, 6'h0d, 6'h07, 6'h10, 6'h11})
      |-> pslverr_out && prdata_out == 32'h0)
      else $error("unmapped access not refused");
endmodule

bind uirq_top uirq_assertions #(.NUM_IN_EP(NUM_IN_EP)) u_chk (.clk_sys_in, .rst_b_in, .pwrite_in, .paddr_in,
   .pwdata_in, .psel_in, .penable_in, .pready_out, .prdata_out, .pslverr_out, .in_ep_event_in,
   .frame_valid_in, .frame_number_in, .usb_irq_out);

// ===== dv/uirq_cpu_model.sv
/* Processor core model: APB master into the USB register space.
   Assumes one clock shared with the register block. */
`timescale 1ns/1ps
module uirq_cpu_model (
   input  wire logic        clk_sys_in,
   input  wire logic        pready_in,
   input  wire logic [31:0] prdata_in,
   input  wire logic        pslverr_in,
   input  wire logic        usb_irq_in,
   output logic             psel_out,
   output logic             penable_out,
   output logic             pwrite_out,
   output logic [7:0]       paddr_out,
   output logic [31:0]      pwdata_out,
   output logic             irq_taken_out
);
   logic ext_irq_en = 1'b0;
   // Request reaches the core only once enabled at core level
   assign irq_taken_out = usb_irq_in & ext_irq_en;
   initial
   begin
      psel_out = 1'b0;
      penable_out = 1'b0;
      pwrite_out = 1'b0;
      paddr_out = 8'h0;
      pwdata_out = 32'h0;
   end
   // One transfer; waits on pready with no cycle count assumed,
   // a hung slave is left to the bench watchdog so it counts as a failure
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
      psel_out <= 1'b1;
      penable_out <= 1'b0;
      pwrite_out <= w;
      paddr_out <= a;
      pwdata_out <= d;
      @(posedge clk_sys_in);
      penable_out <= 1'b1;
      do
      begin
         @(posedge clk_sys_in);
      end
      while (pready_in !== 1'b1);
      q = prdata_in;
      e = pslverr_in;
      psel_out <= 1'b0;
      penable_out <= 1'b0;
      pwdata_out <= ~d;   // No stale data after release
      @(posedge clk_sys_in);
   endtask
endmodule

// ===== dv/usb_irq_flags_frame_regs_tb.sv
/* Testbench for the USB flag and frame register block.
   Drives engine events itself; the core model makes APB transfers. */
`timescale 1ns/1ps
module usb_irq_flags_frame_regs_tb;
   logic        clk_sys_in, rst_b_in, psel, pen, pwr, pready, pslverr, fv, uirq, irq, taken, e;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, q;
   logic [3:0]  ev, en, p;
   logic [10:0] fn, f;
   int          bad_count = 0;
   int          check_count = 0;

   uirq_top dut (.clk_sys_in, .rst_b_in, .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
      .paddr_in(paddr), .pwdata_in(pwdata), .pready_out(pready), .prdata_out(prdata),
      .pslverr_out(pslverr), .in_ep_event_in(ev), .frame_valid_in(fv), .frame_number_in(fn),
      .usb_irq_out(uirq), .irq_out(irq));
   uirq_cpu_model cpu (.clk_sys_in, .pready_in(pready), .prdata_in(prdata), .pslverr_in(pslverr),
      .usb_irq_in(uirq), .psel_out(psel), .penable_out(pen), .pwrite_out(pwr), .paddr_out(paddr),
      .pwdata_out(pwdata), .irq_taken_out(taken));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Expected register words, worked out from the register layout
   function automatic logic [31:0] exp_flags(input logic [3:0] fl);
      return {28'h0, fl};
   endfunction
   function automatic logic [31:0] exp_frame_hi(input logic [10:0] fnum);
      return {29'h0, fnum[10:8]};
   endfunction
   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      cpu.xfer(a, 1'b0, 32'h0, q, e);
      chk(q, x);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      cpu.xfer(a, 1'b1, d, q, e);
   endtask
   // One-cycle engine pulse, then time for the request to show
   task automatic pulse(input logic [3:0] pp, input logic [10:0] ff);
      ev <= pp;
      fv <= 1'b1;
      fn <= ff;
      @(posedge clk_sys_in);
      ev <= 4'h0;
      fv <= 1'b0;
      repeat (2) @(posedge clk_sys_in);
   endtask

   initial
   begin
      clk_sys_in = 1'b0;
      forever #2 clk_sys_in = ~clk_sys_in;
   end
   // Watchdog, well past the expected run of about 700 cycles
   initial
   begin
      #40000;
      bad_count++;
      complete_run();
   end
   initial
   begin
      rst_b_in = 1'b0;
      ev = 4'h0;
      fv = 1'b0;
      fn = 11'h0;
      en = 4'hf;
      void'($urandom(32'hf184f01c));
      repeat (6) @(posedge clk_sys_in);
      rst_b_in <= 1'b1;
      cpu.ext_irq_en = 1'b1;
      // Reset values, then an unmapped word
      rd(8'h08, 32'h0);
      rd(8'h34, 32'h0);
      rd(8'h1c, 32'hf);
      rd(8'h40, 32'h0);
      rd(8'h44, 32'h0);
      rd(8'h3c, 32'h0);
      chk(e, 1'b1);
      // Random events; writes to read-only words must change nothing
      for (int i = 0; i < 24; i++)
      begin
         if (i % 4 == 3)
         begin
            en = 4'($urandom);
            wr(8'h1c, {28'h0, en});
            rd(8'h1c, exp_flags(en));
         end
         p = 4'($urandom);
         f = 11'($urandom);
         pulse(p, f);
         chk(taken, |(p & en));
         wr(8'h08, $urandom);
         wr(8'h34, $urandom);
         rd(8'h34, exp_frame_hi(f));
         rd(8'h08, exp_flags(p));
         rd(8'h08, 32'h0);
      end
      // Event in the setup cycle is returned; one in the clearing cycle survives
      en = 4'hf;
      wr(8'h1c, 32'hf);
      pulse(4'h3, 11'h7ff);
      fork
         rd(8'h08, exp_flags(4'hb));
         begin
            ev <= 4'h8;
            @(posedge clk_sys_in);
            ev <= 4'h0;
            @(posedge clk_sys_in);
            ev <= 4'h4;
            @(posedge clk_sys_in);
            ev <= 4'h0;
         end
      join
      rd(8'h08, 32'h4);
      // System event status: masked, unmasked, cleared bit by bit
      wr(8'h40, 32'h3);
      rd(8'h40, 32'h0);
      pulse(4'h1, 11'h100);
      chk(irq, 1'b0);
      wr(8'h44, 32'h3);
      repeat (2) @(posedge clk_sys_in);
      chk(irq, 1'b1);
      rd(8'h40, 32'h3);
      wr(8'h40, 32'h1);
      rd(8'h40, 32'h2);
      chk(irq, 1'b1);
      wr(8'h40, 32'h2);
      rd(8'h40, 32'h0);
      chk(irq, 1'b0);
      // Frame alone sets only the frame bit, never the endpoint bit
      pulse(4'h0, 11'h2aa);
      rd(8'h40, 32'h2);
      rd(8'h34, exp_frame_hi(11'h2aa));
      chk(irq, 1'b1);
      complete_run();
   end
endmodule
